// ### pkg/dgc_pkg.sv
// What this block does
// - Reset clears operation register to zero
// - Reserved operation bits read zero, write zero
// - On-demand mode blocks channel 0 register writes
// - Bus-available polarity flips in on-demand mode
// - Two-bit field selects fixed or round-robin priority
// - Cancel enable drops a latched external request only in level detect, line high
// - Address error sets flag, suspends, raises interrupt
// - Error flags clear by zero-after-one, end flag by any zero write; all ignore one
// - NMI sets flag anytime, suspends all channels
// - Master enable gates every channel
// - Channel runs only when all conditions met
// - Each request moves one unit, decrements count
// - Auto mode starts without any request
// - Count zero ends transfer, optional end interrupt
// - Clearing either enable suspends channel
// - Request while disabled waits until enabled
// - Misaligned address versus size is address error
// - Auto, external, peripheral; single/dual; burst/steal
// - End flag only on full count completion
// - Detect select picks low level or falling edge
package dgc_pkg;
    localparam int NCH = 4;
    localparam int ADR_W = 8;
    // Register bus map: operation byte offset, channel page number, word index in page
    localparam logic [7:0] ADR_OPCTL = 8'h00;
    localparam logic [3:0] ADR_CH_PAGE0 = 4'h1;
    localparam logic [1:0] CH_SRC = 2'h0;
    localparam logic [1:0] CH_DST = 2'h1;
    localparam logic [1:0] CH_CNT = 2'h2;
    localparam logic [1:0] CH_CTL = 2'h3;
    // Operation control fields
    localparam int OP_MEN = 0;
    localparam int OP_NMI = 1;
    localparam int OP_AE = 2;
    localparam int OP_COD = 4;
    localparam int OP_PR_LO = 8;
    localparam int OP_DDT = 15;
    localparam logic [31:0] OPCTL_RST = 32'h0000_0000;
    localparam logic [31:0] OPCTL_WMASK = 32'h0000_8311;
    // Channel control fields
    localparam int CC_EN = 0;
    localparam int CC_TE = 1;
    localparam int CC_IE = 2;
    localparam int CC_SZ_LO = 4;
    localparam int CC_BURST = 7;
    localparam int CC_MODE_LO = 8;
    localparam int CC_SINGLE = 10;
    localparam int CC_DS = 12;
    localparam logic [31:0] CC_WMASK = 32'h0000_17F5;
    localparam logic [31:0] CH_RST = 32'h0000_0000;
    // Fixed priority orders, lowest first, two bits per entry
    localparam logic [7:0] ORD_P00 = 8'b11_10_01_00;
    localparam logic [7:0] ORD_P01 = 8'b01_11_10_00;
    localparam logic [7:0] ORD_P10 = 8'b11_01_00_10;
    localparam logic [1:0] PR_RR = 2'b11;

    typedef enum logic [2:0] {
        SZ_QUAD = 3'b000,
        SZ_BYTE = 3'b001,
        SZ_WORD = 3'b010,
        SZ_LONG = 3'b011,
        SZ_BLK  = 3'b100
    } dgc_size_e;

    typedef enum logic [1:0] {
        RQ_AUTO = 2'b00,
        RQ_EXT  = 2'b01,
        RQ_PERI = 2'b10
    } dgc_reqm_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } dgc_state_e;

    typedef struct packed {
        logic [31:0] src;
        logic [31:0] dst;
        dgc_size_e   size;
        logic [1:0]  ch;
        logic        single;
        logic        burst;
    } dgc_xfer_s;
endpackage

// ### hw/dgc_top.sv
`timescale 1ns/1ps
module dgc_top #(
    parameter int CNT_W = 24
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [dgc_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  nmi_evt,
    input  wire logic [dgc_pkg::NCH-1:0] external_request_line_n,
    input  wire logic [dgc_pkg::NCH-1:0] periph_req,
    output dgc_pkg::dgc_xfer_s         xfer_cmd,
    output logic                       xfer_valid,
    input  wire logic                  xfer_done,
    output logic [dgc_pkg::NCH-1:0]    request_ack_out,
    output logic                       bus_available_out,
    output logic [dgc_pkg::NCH-1:0]    transfer_end_interrupt,
    output logic                       address_error_interrupt
);
    import dgc_pkg::*;

    // Operation register pieces
    logic              men_r, nmi_r, ae_r, cod_r, ddt_r;
    logic [1:0]        pr_r;
    logic              ae_armed_r, nmi_armed_r;
    // Channel register files
    logic [31:0]       src_r [NCH];
    logic [31:0]       dst_r [NCH];
    logic [CNT_W-1:0]  cnt_r [NCH];
    logic [31:0]       ctl_r [NCH];
    logic [NCH-1:0]    ext_flag_r, ext_prev_n_r;
    // Engine
    dgc_state_e        state_r;
    logic [1:0]        cur_r, last_r;
    logic              ack_r;
    logic [NCH-1:0]    ok, req_raw, req;
    logic [1:0]        pick_ch;
    logic              pick_ok, start, misalign, done_evt;

    // Bus decode
    wire        acc     = wb_cyc_i & wb_stb_i & ~ack_r;
    wire        wr      = acc & wb_we_i;
    wire        rd      = acc & ~wb_we_i;
    wire        op_hit  = (wb_adr_i == ADR_OPCTL);
    wire [3:0]  page    = wb_adr_i[7:4];
    wire [1:0]  rsel    = wb_adr_i[3:2];
    wire        ch_hit  = (page >= ADR_CH_PAGE0) && (page < ADR_CH_PAGE0 + 4'(NCH)) && (wb_adr_i[1:0] == 2'b00);
    wire [1:0]  wch     = 2'(page - ADR_CH_PAGE0);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    function automatic logic [31:0] unit_bytes(input logic [2:0] sz);
        case (sz)
            SZ_BYTE: return 32'h0000_0001;
            SZ_WORD: return 32'h0000_0002;
            SZ_LONG: return 32'h0000_0004;
            SZ_QUAD: return 32'h0000_0008;
            SZ_BLK:  return 32'h0000_0020;
            default: return 32'h0000_0000;
        endcase
    endfunction

    wire [31:0] wmerged = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    wire        op_wr   = wr & op_hit;

    // Bus ack: one cycle after the strobe, unmapped addresses still answer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= acc;
        end
    end
    assign wb_ack_o = ack_r;

    // Read data, registered so it lines up with ack
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd) begin
            if (op_hit) begin
                wb_dat_o <= {16'h0000, ddt_r, 5'b0_0000, pr_r, 3'b000, cod_r, 1'b0, ae_r, nmi_r, men_r};
            end else if (ch_hit) begin
                case (rsel)
                    CH_SRC:  wb_dat_o <= src_r[wch];
                    CH_DST:  wb_dat_o <= dst_r[wch];
                    CH_CNT:  wb_dat_o <= 32'(cnt_r[wch]);
                    default: wb_dat_o <= ctl_r[wch];
                endcase
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // Plain operation fields; reserved bits are never stored
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            men_r <= OPCTL_RST[OP_MEN];
            cod_r <= OPCTL_RST[OP_COD];
            ddt_r <= OPCTL_RST[OP_DDT];
            pr_r  <= OPCTL_RST[OP_PR_LO+1:OP_PR_LO];
        end else if (op_wr) begin
            men_r <= wb_sel_i[0] ? wmerged[OP_MEN] : men_r;
            cod_r <= wb_sel_i[0] ? wmerged[OP_COD] : cod_r;
            pr_r  <= wb_sel_i[1] ? wmerged[OP_PR_LO+1:OP_PR_LO] : pr_r;
            ddt_r <= wb_sel_i[1] ? wmerged[OP_DDT] : ddt_r;
        end
    end

    // Error flags: hardware set beats a same-cycle clear
    wire ae_clr  = op_wr & wb_sel_i[0] & ~wb_dat_i[OP_AE] & ae_armed_r;
    wire nmi_clr = op_wr & wb_sel_i[0] & ~wb_dat_i[OP_NMI] & nmi_armed_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ae_r        <= OPCTL_RST[OP_AE];
            nmi_r       <= OPCTL_RST[OP_NMI];
            ae_armed_r  <= 1'b0;
            nmi_armed_r <= 1'b0;
        end else begin
            ae_r  <= misalign | (ae_r & ~ae_clr);
            nmi_r <= nmi_evt | (nmi_r & ~nmi_clr);
            // A read that saw the flag high arms its clear
            ae_armed_r  <= (ae_armed_r | (rd & op_hit & ae_r)) & ~ae_clr;
            nmi_armed_r <= (nmi_armed_r | (rd & op_hit & nmi_r)) & ~nmi_clr;
        end
    end

    // Per-channel registers, request detection and enable
    generate
        for (genvar c = 0; c < NCH; c++) begin : g_ch
            wire        hit    = wr & ch_hit & (wch == 2'(c)) & ~(ddt_r && c == 0);
            wire        served = done_evt & (cur_r == 2'(c));
            wire        last1  = (cnt_r[c] == CNT_W'(1));
            wire        ds     = ctl_r[c][CC_DS];
            wire        fall   = ext_prev_n_r[c] & ~external_request_line_n[c];
            wire        ext_ok = ~ctl_r[c][CC_TE] & ~nmi_r & ~ae_r;
            wire [1:0]  mode   = ctl_r[c][CC_MODE_LO+1:CC_MODE_LO];

            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    src_r[c] <= CH_RST;
                    dst_r[c] <= CH_RST;
                    cnt_r[c] <= '0;
                    ctl_r[c] <= CH_RST;
                end else begin
                    if (hit && rsel == CH_SRC) begin
                        src_r[c] <= merge(src_r[c], wb_dat_i, wb_sel_i);
                    end else if (served) begin
                        src_r[c] <= src_r[c] + unit_bytes(ctl_r[c][CC_SZ_LO+2:CC_SZ_LO]);
                    end
                    if (hit && rsel == CH_DST) begin
                        dst_r[c] <= merge(dst_r[c], wb_dat_i, wb_sel_i);
                    end else if (served && !ctl_r[c][CC_SINGLE]) begin
                        dst_r[c] <= dst_r[c] + unit_bytes(ctl_r[c][CC_SZ_LO+2:CC_SZ_LO]);
                    end
                    if (hit && rsel == CH_CNT) begin
                        cnt_r[c] <= CNT_W'(merge(32'(cnt_r[c]), wb_dat_i, wb_sel_i));
                    end else if (served) begin
                        cnt_r[c] <= cnt_r[c] - CNT_W'(1);
                    end
                    if (hit && rsel == CH_CTL) begin
                        ctl_r[c] <= (merge(ctl_r[c], wb_dat_i, wb_sel_i) & CC_WMASK)
                                  | (32'(ctl_r[c][CC_TE] & wb_dat_i[CC_TE]) << CC_TE);
                    end
                    // End flag only after the full count; set beats clear
                    if (served && last1) begin
                        ctl_r[c][CC_TE] <= 1'b1;
                    end
                end
            end

            // External request: level when select is 0, latched falling edge when 1
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    ext_prev_n_r[c] <= 1'b1;
                    ext_flag_r[c]   <= 1'b0;
                end else begin
                    ext_prev_n_r[c] <= external_request_line_n[c];
                    if (nmi_r | ae_r) begin
                        ext_flag_r[c] <= 1'b0;
                    end else if (ds && fall && ext_ok) begin
                        ext_flag_r[c] <= 1'b1;
                    end else if (start && pick_ch == 2'(c)) begin
                        ext_flag_r[c] <= 1'b0;
                    end else if (cod_r && !ds && external_request_line_n[c]) begin
                        ext_flag_r[c] <= 1'b0;
                    end
                end
            end

            // Transfer enable: all conditions plus a nonzero count
            assign ok[c] = ctl_r[c][CC_EN] & men_r & ~ctl_r[c][CC_TE] & ~nmi_r & ~ae_r
                         & (cnt_r[c] != '0);
            always_comb begin
                case (mode)
                    RQ_AUTO: req_raw[c] = 1'b1;
                    RQ_EXT:  req_raw[c] = ds ? ext_flag_r[c] : ~external_request_line_n[c];
                    RQ_PERI: req_raw[c] = periph_req[c];
                    default: req_raw[c] = 1'b0;
                endcase
            end
            // A pending request waits here until the channel is enabled
            assign req[c] = req_raw[c] & ok[c];
            assign transfer_end_interrupt[c] = ctl_r[c][CC_TE] & ctl_r[c][CC_IE];
        end
    endgenerate

    // Arbitration among enabled requests
    always_comb begin
        logic [7:0] ord;
        logic [1:0] idx;
        ord     = ORD_P00;
        idx     = 2'b00;
        pick_ch = 2'b00;
        pick_ok = |req;
        case (pr_r)
            2'b00:   ord = ORD_P00;
            2'b01:   ord = ORD_P01;
            2'b10:   ord = ORD_P10;
            default: ord = {last_r, 2'(last_r + 2'd3), 2'(last_r + 2'd2), 2'(last_r + 2'd1)};
        endcase
        for (int i = 3; i >= 0; i--) begin
            idx = ord[2*i +: 2];
            if (req[idx]) begin
                pick_ch = idx;
            end
        end
        // Burst mode keeps the bus on the current channel
        if (ctl_r[cur_r][CC_BURST] && req[cur_r] && last_r == cur_r) begin
            pick_ch = cur_r;
        end
    end

    wire [31:0] amask = unit_bytes(ctl_r[pick_ch][CC_SZ_LO+2:CC_SZ_LO]) - 32'h0000_0001;
    wire        bad   = ((src_r[pick_ch] & amask) != 32'h0000_0000)
                      | (((dst_r[pick_ch] & amask) != 32'h0000_0000) & ~ctl_r[pick_ch][CC_SINGLE]);
    assign misalign = (state_r == ST_IDLE) & pick_ok & bad;
    assign start    = (state_r == ST_IDLE) & pick_ok & ~bad;
    assign done_evt = (state_r == ST_BUSY) & xfer_done;

    // Unit sequencer: one unit per grant, finished before the next choice
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cur_r   <= 2'b00;
            last_r  <= 2'b11;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r <= ST_BUSY;
                        cur_r   <= pick_ch;
                    end
                end
                ST_BUSY: begin
                    if (xfer_done) begin
                        state_r <= ST_IDLE;
                        last_r  <= cur_r;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Command to the bus side, held until done
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            xfer_cmd        <= '0;
            request_ack_out <= '0;
        end else begin
            request_ack_out <= '0;
            if (start) begin
                xfer_cmd.src    <= src_r[pick_ch];
                xfer_cmd.dst    <= dst_r[pick_ch];
                xfer_cmd.size   <= dgc_size_e'(ctl_r[pick_ch][CC_SZ_LO+2:CC_SZ_LO]);
                xfer_cmd.ch     <= pick_ch;
                xfer_cmd.single <= ctl_r[pick_ch][CC_SINGLE];
                xfer_cmd.burst  <= ctl_r[pick_ch][CC_BURST];
                request_ack_out[pick_ch] <= 1'b1;
            end
        end
    end

    assign xfer_valid = (state_r == ST_BUSY);
    // Polarity follows the mode bit: active low while on-demand
    assign bus_available_out = xfer_valid ^ ddt_r;
    assign address_error_interrupt = ae_r;

    // Checks
    chk_rsvd_zero: assert property (@(posedge ref_clk) disable iff (rst)
        (rd && op_hit) |=> (wb_dat_o[31:16] == 16'h0000 && wb_dat_o[14:10] == 5'h00
                            && wb_dat_o[7:5] == 3'h0 && wb_dat_o[3] == 1'b0))
        else $error("reserved operation bits read nonzero");
    chk_ondemand_mask: assert property (@(posedge ref_clk) disable iff (rst)
        (ddt_r && wr && ch_hit && wch == 2'd0 && !(done_evt && cur_r == 2'd0)) |=> $stable(cnt_r[0]) && $stable(src_r[0]))
        else $error("channel 0 written in on-demand mode");
    chk_bus_available_out_polarity: assert property (@(posedge ref_clk) disable iff (rst)
        bus_available_out == (ddt_r ? (state_r != ST_BUSY) : (state_r == ST_BUSY)))
        else $error("bus available polarity wrong");
    chk_fixed_prio: assert property (@(posedge ref_clk) disable iff (rst)
        (start && pr_r == 2'b10 && req[2] && !ctl_r[cur_r][CC_BURST]) |=> cur_r == 2'd2)
        else $error("fixed priority not honoured");
    chk_ae_write_one: assert property (@(posedge ref_clk) disable iff (rst)
        (!ae_r && !misalign) |=> !ae_r)
        else $error("address error flag set without cause");
    chk_nmi_sets: assert property (@(posedge ref_clk) disable iff (rst)
        nmi_evt |=> nmi_r ##1 (nmi_r || $past(nmi_clr)))
        else $error("nmi flag not set");
    chk_no_start_off: assert property (@(posedge ref_clk) disable iff (rst)
        start |-> (men_r && !nmi_r && !ae_r && ctl_r[pick_ch][CC_EN] && !ctl_r[pick_ch][CC_TE]))
        else $error("unit started on disabled channel");
    chk_count_dec: assert property (@(posedge ref_clk) disable iff (rst)
        (done_evt && !(wr && ch_hit)) |=> cnt_r[$past(cur_r)] == $past(cnt_r[cur_r]) - CNT_W'(1))
        else $error("count not decremented");
    chk_end_flag: assert property (@(posedge ref_clk) disable iff (rst)
        (done_evt && cnt_r[cur_r] == CNT_W'(1)) |=> ctl_r[$past(cur_r)][CC_TE] ##0 !ok[$past(cur_r)])
        else $error("end flag not set at count zero");
    chk_ae_suspends: assert property (@(posedge ref_clk) disable iff (rst)
        misalign |=> (ae_r && !start) [*2])
        else $error("address error did not suspend");
endmodule

// ### verif/dgc_bus_model.sv
`timescale 1ns/1ps
module dgc_bus_model (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       xfer_valid,
    input  wire logic [1:0] dly,
    output logic            xfer_done
);
    logic [1:0] wait_r;

    // Finishes each unit after dly extra cycles; a larger dly plays slow memory
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wait_r    <= 2'h0;
            xfer_done <= 1'b0;
        end else if (xfer_valid && !xfer_done) begin
            if (wait_r == dly) begin
                xfer_done <= 1'b1;
                wait_r    <= 2'h0;
            end else begin
                wait_r <= wait_r + 2'h1;
            end
        end else begin
            xfer_done <= 1'b0; // One-cycle pulse only
        end
    end
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import dgc_pkg::*;
    logic              ref_clk;
    logic              rst;
    logic              wb_cyc;
    logic              wb_stb;
    logic              wb_we;
    logic [ADR_W-1:0]  wb_adr;
    logic [31:0]       wb_dat_w;
    logic [31:0]       wb_dat_o;
    logic              wb_ack_o;
    logic              nmi_evt;
    dgc_xfer_s         xfer_cmd;
    logic              xfer_valid;
    logic              xfer_done;
    logic [NCH-1:0]    request_ack_out;
    logic              bus_available_out;
    logic [NCH-1:0]    transfer_end_interrupt;
    logic              address_error_interrupt;
    logic [1:0]        dly;
    logic [NCH-1:0]    periph_req;
    logic [31:0]       seed;
    logic [31:0]       src_a;
    int                errors;
    int                cmp_count;
    logic [31:0]       exp_rd[$];
    logic [36:0]       exp_xf[$];

    dgc_top dgc_top_i (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .nmi_evt(nmi_evt), .external_request_line_n(4'hF), .periph_req(periph_req), .xfer_cmd(xfer_cmd),
        .xfer_valid(xfer_valid), .xfer_done(xfer_done), .request_ack_out(request_ack_out),
        .bus_available_out(bus_available_out), .transfer_end_interrupt(transfer_end_interrupt),
        .address_error_interrupt(address_error_interrupt));

    dgc_bus_model dgc_bus_model_i (.ref_clk(ref_clk), .rst(rst), .xfer_valid(xfer_valid), .dly(dly),
        .xfer_done(xfer_done));

    // Free-running bench clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic tally_and_finish();
        if (errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [36:0] got, input logic [36:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic give_up(input string what);
        errors++;
        $display("wrong value at %0t: %s never came", $time, what);
        tally_and_finish();
    endtask

    // Classic single cycle; request held until the edge that samples ack
    task automatic bus(input logic [ADR_W-1:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= w;
        wb_adr   <= a;
        wb_dat_w <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) give_up("bus ack");
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        bus(a, 1'b0, 32'h0000_0000);
    endtask

    // Waits until every noted unit was issued and the link went idle
    task automatic wait_xf();
        int n;
        for (n = 0; n < 300 && (exp_xf.size() != 0 || xfer_valid !== 1'b0); n++) @(posedge ref_clk);
        if (n == 300) give_up("transfer end");
    endtask

    // Results meet their oldest note here, read data and issued units alike
    always @(posedge ref_clk) begin
        if (wb_ack_o === 1'b1 && wb_we === 1'b0 && exp_rd.size() != 0) begin
            check({5'h0, wb_dat_o}, {5'h0, exp_rd.pop_front()}, "read data");
        end
        if (request_ack_out !== 4'h0) begin
            if (exp_xf.size() == 0) check({xfer_valid, request_ack_out, xfer_cmd.src}, 37'h0, "extra unit");
            else check({xfer_valid, request_ack_out, xfer_cmd.src}, exp_xf.pop_front(), "unit");
        end
    end

    initial begin
        int n;
        seed = 32'h0000_0037;
        rst = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = '0;
        wb_dat_w = 32'h0000_0000;
        nmi_evt = 1'b0;
        periph_req = 4'h0;
        dly = 2'h0;
        errors = 0;
        cmp_count = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        rd(ADR_OPCTL, OPCTL_RST);
        wr(ADR_OPCTL, 32'hFFFF_FFFF);
        rd(ADR_OPCTL, 32'h0000_8311);
        check({36'h0, bus_available_out}, 37'h1, "idle bus available");
        wr(8'h10, 32'h0000_1234);
        rd(8'h10, 32'h0000_0000);
        wr(ADR_OPCTL, 32'h0000_0000);
        check({36'h0, bus_available_out}, 37'h0, "idle bus available");
        // A one-cycle event must leave the flag standing
        @(posedge ref_clk);
        nmi_evt <= 1'b1;
        @(posedge ref_clk);
        nmi_evt <= 1'b0;
        rd(ADR_OPCTL, 32'h0000_0002);
        wr(ADR_OPCTL, 32'h0000_0000);
        rd(ADR_OPCTL, 32'h0000_0000);
        // Auto request on channel 1, random aligned source, random memory delay
        src_a = xs() & 32'h0000_FFFC;
        dly <= seed[1:0];
        wr(8'h20, src_a);
        wr(8'h24, 32'h0000_2000);
        wr(8'h28, 32'h0000_0002);
        wr(8'h2C, 32'h0000_0035);
        exp_xf.push_back({1'b1, 4'b0010, src_a});
        exp_xf.push_back({1'b1, 4'b0010, src_a + 32'h0000_0004});
        wr(ADR_OPCTL, 32'h0000_0001);
        wait_xf();
        rd(8'h2C, 32'h0000_0037);
        rd(8'h28, 32'h0000_0000);
        rd(8'h20, src_a + 32'h0000_0008);
        check({33'h0, transfer_end_interrupt}, 37'h2, "end interrupt");
        // Two channels wait with master off, then order 2 before 0
        src_a = xs();
        dly <= src_a[1:0];
        wr(ADR_OPCTL, 32'h0000_0200);
        wr(8'h10, 32'h0000_0040);
        wr(8'h18, 32'h0000_0001);
        wr(8'h1C, 32'h0000_0031);
        wr(8'h30, 32'h0000_0080);
        wr(8'h38, 32'h0000_0001);
        wr(8'h3C, 32'h0000_0031);
        exp_xf.push_back({1'b1, 4'b0100, 32'h0000_0080});
        exp_xf.push_back({1'b1, 4'b0001, 32'h0000_0040});
        wr(ADR_OPCTL, 32'h0000_0201);
        wait_xf();
        // Misaligned source on channel 3: flag, interrupt, nothing issued
        wr(8'h40, 32'h0000_0101);
        wr(8'h48, 32'h0000_0001);
        wr(8'h4C, 32'h0000_0031);
        for (n = 0; n < 50 && address_error_interrupt !== 1'b1; n++) @(posedge ref_clk);
        if (n == 50) give_up("address error");
        rd(ADR_OPCTL, 32'h0000_0205);
        wr(ADR_OPCTL, 32'h0000_0200);
        rd(ADR_OPCTL, 32'h0000_0200);
        check({36'h0, address_error_interrupt}, 37'h0, "error interrupt");
        // Peripheral request on channel 0: nothing moves until the request line rises
        wr(8'h4C, 32'h0000_0000);
        wr(8'h10, 32'h0000_0100);
        wr(8'h18, 32'h0000_0001);
        wr(8'h1C, 32'h0000_0231);
        wr(ADR_OPCTL, 32'h0000_0201);
        repeat (5) @(posedge ref_clk);
        exp_xf.push_back({1'b1, 4'b0001, 32'h0000_0100});
        periph_req <= 4'h1;
        wait_xf();
        periph_req <= 4'h0;
        rd(8'h1C, 32'h0000_0233);
        tally_and_finish();
    end
endmodule
